// [outctl_defs.vh]
// constants for the dac output control and detect block
`ifndef OUTCTL_DEFS_VH
`define OUTCTL_DEFS_VH
`define REG_GAIN 12'h000
`define REG_ZERO 12'h004
`define REG_ROUTE 12'h008
`define REG_FSMUTE 12'h00c
`define REG_STATUS 12'h010
// full-scale flags sit at word index 6; byte address is four times it
`define REG_FSFLAGS_IDX 10'h006
`define REG_FSFLAGS {`REG_FSFLAGS_IDX, 2'h0}
`define ZERO_COUNT 8192
`define FS_COUNT 2048
`define RST_CLR_DELAY 4
`define LVL_LOW 2'h0
`define LVL_MID 2'h1
`define LVL_HIGH 2'h2
`define ZERO_EN_RST 1'h1
`define ATS_RST 3'h0
`endif

// [outctl.v]
// dac output gain, zero detect, routing and dsd full-scale mute
//
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
`include "outctl_defs.vh"
module outctl #(
    parameter DW = 32,
    parameter ZERO_CYCLES = `ZERO_COUNT
) (
    input wire MCLK,
    input wire RESETN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire PIN_CONTROL,
    input wire GAIN_PIN,
    input wire RIGHT_INVERT_PIN,
    input wire DSD_MODE,
    input wire SAMPLE_VALID,
    input wire [DW-1:0] LEFT_IN,
    input wire [DW-1:0] RIGHT_IN,
    input wire DSD_BIT_VALID,
    input wire DSD_LEFT_IN,
    input wire DSD_RIGHT_IN,
    output reg [DW-1:0] LEFT_OUT,
    output reg [DW-1:0] RIGHT_OUT,
    output reg [1:0] OUTPUT_LEVEL,
    output reg ZERO_FLAG_LEFT,
    output reg ZERO_FLAG_RIGHT,
    output reg FULLSCALE_MUTE,
    output reg RAPID_MUTE,
    output reg [2:0] MUTE_TIME
);
    // pin-sourced levels pass two flops
    reg [3:0] pin_s1_q;
    reg [3:0] pin_s2_q;
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
        end else begin
            pin_s1_q <= {PIN_CONTROL, GAIN_PIN, RIGHT_INVERT_PIN, DSD_MODE};
            pin_s2_q <= pin_s1_q;
        end
    end
    wire pin_ctl = pin_s2_q[3];
    wire gain_pin = pin_s2_q[2];
    wire right_invert_pin = pin_s2_q[1];
    wire dsd = pin_s2_q[0];

    // control registers
    reg [2:0] gain_code_q;
    reg dsd_cutoff_select_q;
    reg zero_detect_enable_q;
    reg zero_flag_polarity_q;
    reg zero_flag_combined_mode_q;
    reg soft_reset_n_q;
    reg single_source_q;
    reg channel_swap_q;
    reg left_invert_q;
    reg right_invert_q;
    reg dsd_path_select_q;
    reg fullscale_mute_enable_q;
    reg manual_recovery_select_q;
    reg recovery_request_q;
    reg [2:0] transition_time_select_q;
    reg fs_flag_l_q;
    reg fs_flag_r_q;
    reg muted_q;

    wire wr = PSEL & PENABLE & PWRITE;
    wire valid_addr = (PADDR == `REG_GAIN) || (PADDR == `REG_ZERO) ||
        (PADDR == `REG_ROUTE) || (PADDR == `REG_FSMUTE) ||
        (PADDR == `REG_STATUS) || (PADDR == `REG_FSFLAGS);
    wire recover_now;

    // apb writes; request bit self-clear beats a same-cycle set
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            gain_code_q <= 3'h0;
            dsd_cutoff_select_q <= 1'b0;
            zero_detect_enable_q <= `ZERO_EN_RST;
            zero_flag_polarity_q <= 1'b0;
            zero_flag_combined_mode_q <= 1'b0;
            soft_reset_n_q <= 1'b0;
            single_source_q <= 1'b0;
            channel_swap_q <= 1'b0;
            left_invert_q <= 1'b0;
            right_invert_q <= 1'b0;
            dsd_path_select_q <= 1'b0;
            fullscale_mute_enable_q <= 1'b0;
            manual_recovery_select_q <= 1'b0;
            recovery_request_q <= 1'b0;
            transition_time_select_q <= `ATS_RST;
        end else begin
            if (wr && PADDR == `REG_GAIN) begin
                gain_code_q <= PWDATA[2:0];
                dsd_cutoff_select_q <= PWDATA[4];
            end
            if (wr && PADDR == `REG_ZERO) begin
                zero_detect_enable_q <= PWDATA[0];
                zero_flag_polarity_q <= PWDATA[1];
                zero_flag_combined_mode_q <= PWDATA[2];
                soft_reset_n_q <= PWDATA[3];
            end
            if (wr && PADDR == `REG_ROUTE) begin
                single_source_q <= PWDATA[0];
                channel_swap_q <= PWDATA[1];
                left_invert_q <= PWDATA[2];
                right_invert_q <= PWDATA[3];
            end
            // host holds reset; enable is taken any time
            if (wr && PADDR == `REG_FSMUTE) begin
                fullscale_mute_enable_q <= PWDATA[0];
                manual_recovery_select_q <= PWDATA[1];
                dsd_path_select_q <= PWDATA[3];
                transition_time_select_q <= PWDATA[6:4];
            end
            if (recover_now)
                recovery_request_q <= 1'b0;
            else if (wr && PADDR == `REG_FSMUTE)
                recovery_request_q <= PWDATA[2];
        end
    end

    // apb read and answer: one wait-free access cycle
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~valid_addr;
            PRDATA <= 32'h00000000;
            if (PSEL && !PENABLE && !PWRITE) begin
                case (PADDR)
                `REG_GAIN: PRDATA <= {27'h0, dsd_cutoff_select_q,
                                      1'b0, gain_code_q};
                `REG_ZERO: PRDATA <= {28'h0, soft_reset_n_q,
                    zero_flag_combined_mode_q, zero_flag_polarity_q,
                    zero_detect_enable_q};
                `REG_ROUTE: PRDATA <= {28'h0, right_invert_q,
                    left_invert_q, channel_swap_q, single_source_q};
                `REG_FSMUTE: PRDATA <= {25'h0, transition_time_select_q,
                    dsd_path_select_q, recovery_request_q,
                    manual_recovery_select_q, fullscale_mute_enable_q};
                `REG_STATUS: PRDATA <= {28'h0, muted_q, OUTPUT_LEVEL,
                                        ZERO_FLAG_LEFT};
                `REG_FSFLAGS: PRDATA <= {30'h0, fs_flag_r_q, fs_flag_l_q};
                default: PRDATA <= 32'h00000000;
                endcase
            end
        end
    end
    // apb transfer completes in access phase, wr uses PENABLE too
    // (PREADY high during access since set in setup cycle)

    reg [1:0] level_d;
    always @* begin
        level_d = `LVL_LOW;
        if (pin_ctl) begin
            if (!dsd)
                level_d = gain_pin ? `LVL_HIGH : `LVL_MID;
        end else if (!dsd) begin
            if (gain_code_q[2:1] == 2'h0)
                level_d = `LVL_MID;
            else if (gain_code_q[2:1] == 2'h2)
                level_d = `LVL_HIGH;
        end else if (!dsd_path_select_q) begin
            if (gain_code_q == 3'h0)
                level_d = `LVL_MID;
            else if (gain_code_q == 3'h4)
                level_d = `LVL_HIGH;
        end
    end

    reg [DW-1:0] rl_d;
    reg [DW-1:0] rr_d;
    always @* begin
        rl_d = LEFT_IN;
        rr_d = RIGHT_IN;
        if (pin_ctl) begin
            if (right_invert_pin)
                rr_d = (~RIGHT_IN) + {{(DW-1){1'b0}}, 1'b1};
        end else begin
            case ({single_source_q, channel_swap_q})
            2'h1: begin
                rl_d = RIGHT_IN;
                rr_d = LEFT_IN;
            end
            2'h2: rr_d = LEFT_IN;
            2'h3: rl_d = RIGHT_IN;
            default: rl_d = LEFT_IN;
            endcase
            if (left_invert_q)
                rl_d = (~rl_d) + {{(DW-1){1'b0}}, 1'b1};
            if (right_invert_q)
                rr_d = (~rr_d) + {{(DW-1){1'b0}}, 1'b1};
        end
    end

    // per-channel zero counters, count in word-clock samples
    wire [1:0] nz = {RIGHT_IN != {DW{1'b0}}, LEFT_IN != {DW{1'b0}}};
    reg [1:0] zdet_q;
    reg [2:0] rcnt_q [0:1];
    reg [1:0] rel_q;
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : zch
            reg [13:0] zcnt_q;
            always @(posedge MCLK or negedge RESETN) begin
                if (!RESETN) begin
                    zcnt_q <= 14'h0000;
                    zdet_q[g] <= 1'b0;
                    rcnt_q[g] <= 3'h0;
                    rel_q[g] <= 1'b0;
                end else if (!soft_reset_n_q) begin
                    zcnt_q <= 14'h0000;
                    zdet_q[g] <= 1'b0;
                    rcnt_q[g] <= 3'h0;
                    rel_q[g] <= 1'b0;
                end else if (SAMPLE_VALID) begin
                    if (nz[g]) begin
                        zcnt_q <= 14'h0000;
                        zdet_q[g] <= 1'b0;
                    end else if (zcnt_q == ZERO_CYCLES - 1) begin
                        zdet_q[g] <= 1'b1;
                    end else begin
                        zcnt_q <= zcnt_q + 14'h0001;
                    end
                    // release 4 to 5 samples after first nonzero
                    if (nz[g] && rcnt_q[g] == 3'h0 && !rel_q[g])
                        rcnt_q[g] <= 3'h1;
                    else if (rcnt_q[g] == `RST_CLR_DELAY) begin
                        rel_q[g] <= 1'b1;
                        rcnt_q[g] <= 3'h0;
                    end else if (rcnt_q[g] != 3'h0)
                        rcnt_q[g] <= rcnt_q[g] + 3'h1;
                end
            end
        end
    endgenerate

    // flag logic: drop on a strobed nonzero word, combined
    // lines between strobes carry no sample, so they must not clear it
    reg [1:0] zf_d;
    always @* begin
        zf_d[0] = (zdet_q[0] && !(SAMPLE_VALID && nz[0])) || !rel_q[0];
        zf_d[1] = (zdet_q[1] && !(SAMPLE_VALID && nz[1])) || !rel_q[1];
        if (zero_flag_combined_mode_q)
            zf_d = {2{zf_d[0] & zf_d[1]}};
        if (!soft_reset_n_q)
            zf_d = 2'h3;
        if (!zero_detect_enable_q || (dsd && dsd_path_select_q))
            zf_d = 2'h0;
    end

    reg [10:0] fcnt_l_q;
    reg [10:0] fcnt_r_q;
    reg last_l_q;
    reg last_r_q;
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            fcnt_l_q <= 11'h000;
            fcnt_r_q <= 11'h000;
            last_l_q <= 1'b0;
            last_r_q <= 1'b0;
            fs_flag_l_q <= 1'b0;
            fs_flag_r_q <= 1'b0;
        end else if (!dsd) begin
            fcnt_l_q <= 11'h000;
            fcnt_r_q <= 11'h000;
            fs_flag_l_q <= 1'b0;
            fs_flag_r_q <= 1'b0;
        end else if (DSD_BIT_VALID) begin
            last_l_q <= DSD_LEFT_IN;
            last_r_q <= DSD_RIGHT_IN;
            if (DSD_LEFT_IN != last_l_q) begin
                fcnt_l_q <= 11'h000;
                fs_flag_l_q <= 1'b0;
            end else if (fcnt_l_q == `FS_COUNT - 2)
                fs_flag_l_q <= 1'b1;
            else
                fcnt_l_q <= fcnt_l_q + 11'h001;
            if (DSD_RIGHT_IN != last_r_q) begin
                fcnt_r_q <= 11'h000;
                fs_flag_r_q <= 1'b0;
            end else if (fcnt_r_q == `FS_COUNT - 2)
                fs_flag_r_q <= 1'b1;
            else
                fcnt_r_q <= fcnt_r_q + 11'h001;
        end
    end

    // mute state: off when disabled, auto, hold
    wire fs_any = fs_flag_l_q | fs_flag_r_q;
    assign recover_now = muted_q & ~fs_any & manual_recovery_select_q &
        recovery_request_q;
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN)
            muted_q <= 1'b0;
        else if (!fullscale_mute_enable_q)
            muted_q <= 1'b0;
        else if (fs_any)
            muted_q <= 1'b1;
        else if (!manual_recovery_select_q)
            muted_q <= 1'b0;
        else if (recover_now)
            muted_q <= 1'b0;
    end

    // registered outputs; time and path drive mute both ways
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            LEFT_OUT <= {DW{1'b0}};
            RIGHT_OUT <= {DW{1'b0}};
            OUTPUT_LEVEL <= `LVL_LOW;
            ZERO_FLAG_LEFT <= 1'b0;
            ZERO_FLAG_RIGHT <= 1'b0;
            FULLSCALE_MUTE <= 1'b0;
            RAPID_MUTE <= 1'b0;
            MUTE_TIME <= `ATS_RST;
        end else begin
            LEFT_OUT <= rl_d;
            RIGHT_OUT <= rr_d;
            OUTPUT_LEVEL <= level_d;
            ZERO_FLAG_LEFT <= zf_d[0] ^ zero_flag_polarity_q;
            ZERO_FLAG_RIGHT <= zf_d[1] ^ zero_flag_polarity_q;
            FULLSCALE_MUTE <= muted_q;
            RAPID_MUTE <= dsd_path_select_q;
            MUTE_TIME <= transition_time_select_q;
        end
    end
endmodule

// [outctl_properties.sv]
// port-level checks for the dac output control block
`timescale 1ns/100ps
module outctl_props (
    input wire MCLK,
    input wire RESETN,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire [1:0] OUTPUT_LEVEL,
    input wire ZERO_FLAG_LEFT,
    input wire ZERO_FLAG_RIGHT,
    input wire FULLSCALE_MUTE,
    input wire RAPID_MUTE,
    input wire [2:0] MUTE_TIME
);
    reg [3:0] zero_q;
    reg [6:0] mute_q;
    reg [1:0] age_q;
    wire wr = PSEL & PENABLE & PWRITE & PREADY & ~PSLVERR;
    wire calm = age_q == 2'h3;
    // shadow control words; age_q gives outputs time to follow a write
    always @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            zero_q <= 4'h1;
            mute_q <= 7'h00;
            age_q <= 2'h0;
        end else begin
            if (wr && PADDR == 12'h004)
                zero_q <= PWDATA[3:0];
            if (wr && PADDR == 12'h00c)
                mute_q <= PWDATA[6:0];
            age_q <= wr ? 2'h0 : age_q + {1'b0, ~calm};
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    a_ready_follows: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("no answer after setup");
    a_ready_single: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    a_err_quiet: assert property (PSLVERR |-> PREADY && (PWRITE || !PRDATA))
        else $error("error answer malformed");
    a_err_mapped: assert property (PREADY && PADDR == 12'h004 |-> !PSLVERR)
        else $error("mapped word refused");
    a_level_legal: assert property (OUTPUT_LEVEL != 2'h3)
        else $error("level code out of range");
    a_flags_idle: assert property (calm && !zero_q[0] |->
        ZERO_FLAG_LEFT == zero_q[1] && ZERO_FLAG_RIGHT == zero_q[1])
        else $error("disabled flags not idle");
    a_no_mute: assert property (calm && !mute_q[0] |-> !FULLSCALE_MUTE)
        else $error("mute while disabled");
    a_path_mode: assert property (calm |-> RAPID_MUTE == mute_q[3])
        else $error("mute kind differs from path");
    a_time_follows: assert property (calm |-> MUTE_TIME == mute_q[6:4])
        else $error("mute time differs from setting");
endmodule
bind outctl outctl_props u_props (.MCLK, .RESETN, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .OUTPUT_LEVEL,
    .ZERO_FLAG_LEFT, .ZERO_FLAG_RIGHT, .FULLSCALE_MUTE, .RAPID_MUTE,
    .MUTE_TIME);

// [sample_src.sv]
// model of the serial receiver feeding pcm words or dsd bits
`timescale 1ns/100ps
module sample_src (
    input wire clk,
    output reg valid,
    output reg [31:0] left,
    output reg [31:0] right,
    output reg dvalid,
    output reg dleft,
    output reg dright
);
    initial {valid, dvalid, left, right, dleft, dright} = 68'h0;
    // one strobed unit; lines flip after it so stale data never matches
    task step(input pcm, input [31:0] l, input [31:0] r);
        begin
            @(posedge clk);
            {valid, dvalid} <= {pcm, ~pcm};
            {left, right, dleft, dright} <= {l, r, l[0], r[0]};
            @(posedge clk);
            {valid, dvalid} <= 2'h0;
            {left, right, dleft, dright} <= ~{l, r, l[0], r[0]};
        end
    endtask
endmodule

// [tb.sv]
// self-checking bench for the dac output control block
`timescale 1ns/100ps
`include "outctl_defs.vh"
module tb;
    reg MCLK, RESETN, PSEL, PENABLE, PWRITE;
    reg PIN_CONTROL, GAIN_PIN, RIGHT_INVERT_PIN, DSD_MODE, err;
    reg [11:0] PADDR;
    reg [31:0] PWDATA, q, a, b;
    wire [31:0] PRDATA, LEFT_IN, RIGHT_IN, LEFT_OUT, RIGHT_OUT;
    wire PREADY, PSLVERR, SAMPLE_VALID, DSD_BIT_VALID, DSD_LEFT_IN;
    wire DSD_RIGHT_IN, ZERO_FLAG_LEFT, ZERO_FLAG_RIGHT, FULLSCALE_MUTE;
    wire RAPID_MUTE;
    wire [1:0] OUTPUT_LEVEL;
    wire [2:0] MUTE_TIME;
    integer failures = 0, n_tests = 0, cyc = 0, i;
    // short zero count keeps the detect runs brief
    outctl #(.ZERO_CYCLES(16)) DUT (.MCLK, .RESETN, .PSEL, .PENABLE, .PWRITE,
        .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .PIN_CONTROL, .GAIN_PIN,
        .RIGHT_INVERT_PIN, .DSD_MODE, .SAMPLE_VALID, .LEFT_IN, .RIGHT_IN,
        .DSD_BIT_VALID, .DSD_LEFT_IN, .DSD_RIGHT_IN, .LEFT_OUT, .RIGHT_OUT,
        .OUTPUT_LEVEL, .ZERO_FLAG_LEFT, .ZERO_FLAG_RIGHT, .FULLSCALE_MUTE,
        .RAPID_MUTE, .MUTE_TIME);
    sample_src src (.clk(MCLK), .valid(SAMPLE_VALID), .left(LEFT_IN),
        .right(RIGHT_IN), .dvalid(DSD_BIT_VALID), .dleft(DSD_LEFT_IN),
        .dright(DSD_RIGHT_IN));
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    // hang guard, well above the length of the full sequence
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures = failures + 1;
            give_verdict;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    // one transfer; request held until ready is seen at an edge
    task apb(input w, input [11:0] ad, input [31:0] d);
        begin
            @(posedge MCLK);
            {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'h2, w, ad, d};
            @(posedge MCLK);
            PENABLE <= 1'b1;
            @(posedge MCLK);
            while (PREADY !== 1'b1)
                @(posedge MCLK);
            q = PRDATA;
            err = PSLVERR;
            {PSEL, PENABLE} <= 2'h0;
        end
    endtask
    task w(input integer n);
        begin
            repeat (n) @(posedge MCLK);
            #1;
        end
    endtask
    // n samples of one pair, then flags compared as {left, right}
    task zf(input integer n, input [31:0] l, input [31:0] r, input [1:0] e);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1)
                src.step(1'b1, l, r);
            w(2);
            chk({ZERO_FLAG_LEFT, ZERO_FLAG_RIGHT}, e);
        end
    endtask
    // dsd bits: left stuck high when s is set, right always toggling
    task ds(input integer n, input s, input e);
        integer k;
        begin
            for (k = 0; k < n; k = k + 1)
                src.step(1'b0, s | k[0], k[0]);
            w(3);
            chk(FULLSCALE_MUTE, e);
        end
    endtask
    function [1:0] lvl(input [2:0] g, input d, input y);
        begin
            if (d && y)
                lvl = 2'h0;
            else if (d)
                lvl = (g == 3'h0) ? 2'h1 : ((g == 3'h4) ? 2'h2 : 2'h0);
            else
                lvl = g[1] ? 2'h0 : (g[2] ? 2'h2 : 2'h1);
        end
    endfunction
    function [31:0] neg(input s, input [31:0] v);
        neg = s ? -v : v;
    endfunction
    task give_verdict;
        begin
            if (failures == 0 && n_tests > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        void'($urandom(57));
        {RESETN, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = 48'h0;
        {PIN_CONTROL, GAIN_PIN, RIGHT_INVERT_PIN, DSD_MODE} = 4'h0;
        repeat (16) @(posedge MCLK);
        RESETN <= 1'b1;
        zf(0, 0, 0, 2'h3);
        apb(0, `REG_ZERO, 0);
        chk(q, 32'h1);
        apb(0, 12'h020, 0);
        chk({err, q[30:0]}, 32'h80000000);
        apb(1, `REG_FSMUTE, 32'h1);
        // gain codes over pcm, dsd normal and bypass; cutoff bit kept clear
        for (i = 0; i < 24; i = i + 1) begin
            @(posedge MCLK);
            DSD_MODE <= i >= 8;
            apb(1, `REG_FSMUTE, {28'h0, i >= 16, 3'h1});
            apb(1, `REG_GAIN, {29'h0, i[2:0]});
            w(4);
            chk(OUTPUT_LEVEL, lvl(i[2:0], i >= 8, i >= 16));
        end
        apb(1, `REG_FSMUTE, 32'h1);
        DSD_MODE <= 1'b0;
        apb(1, `REG_ZERO, 32'h9);
        zf(2, 1, 1, 2'h3);
        zf(4, 1, 1, 2'h0);
        // every selector code with random samples
        for (i = 0; i < 16; i = i + 1) begin
            apb(1, `REG_ROUTE, i);
            a = $urandom;
            b = $urandom;
            src.step(1'b1, a, b);
            // outputs follow the lines every cycle: look while the word stands
            w(0);
            chk(LEFT_OUT, neg(i[2], i[1] ? b : a));
            chk(RIGHT_OUT, neg(i[3], (i[0] ^ i[1]) ? a : b));
        end
        zf(15, 0, 0, 2'h0);
        zf(1, 0, 0, 2'h3);
        zf(1, 5, 0, 2'h1);
        apb(1, `REG_ZERO, 32'hd);
        zf(16, 0, 1, 2'h0);
        zf(16, 0, 0, 2'h3);
        apb(1, `REG_ZERO, 32'hb);
        zf(16, 0, 0, 2'h0);
        zf(1, 3, 3, 2'h3);
        for (i = 0; i < 2; i = i + 1) begin
            apb(1, `REG_ZERO, 8 + 2 * i);
            zf(16, 0, 0, {2{i[0]}});
        end
        apb(1, `REG_ZERO, 32'h9);
        apb(1, `REG_FSMUTE, 32'h9);
        DSD_MODE <= 1'b1;
        zf(20, 0, 0, 2'h0);
        // pins must override the right-only, left-inverted register routing
        apb(1, `REG_ROUTE, 32'h7);
        for (i = 0; i < 2; i = i + 1) begin
            {PIN_CONTROL, DSD_MODE, GAIN_PIN, RIGHT_INVERT_PIN} <= {2'h2, i[0], i[0]};
            w(4);
            a = $urandom;
            b = $urandom;
            src.step(1'b1, a, b);
            w(0);
            chk(OUTPUT_LEVEL, 1 + i);
            chk(LEFT_OUT, a);
            chk(RIGHT_OUT, neg(i[0], b));
        end
        {PIN_CONTROL, DSD_MODE} <= 2'h1;
        apb(1, `REG_FSMUTE, 32'h51);
        ds(2047, 1, 0);
        apb(0, `REG_FSFLAGS, 0);
        chk(q, 32'h0);
        ds(2, 1, 1);
        apb(0, `REG_FSFLAGS, 0);
        chk(q, 32'h1);
        chk(MUTE_TIME, 3'h5);
        apb(0, `REG_STATUS, 0);
        chk(q, 32'h8);
        ds(8, 0, 0);
        apb(1, `REG_FSMUTE, 32'h53);
        ds(2049, 1, 1);
        ds(8, 0, 1);
        apb(1, `REG_FSMUTE, 32'h57);
        ds(8, 0, 0);
        apb(0, `REG_FSMUTE, 0);
        chk(q, 32'h53);
        give_verdict;
    end
endmodule
